//--- ccts_top.sv
// capture, trigger and timer-select logic for two capture/compare/pwm units
//
// Notes on behaviour
// - control byte and low/high value bytes per unit, read/write.
// - capture/compare on first or third timer; pwm on second.
// - each capture/compare unit's timer comes from third timer control bits.
// - units run together; same class may share a timer.
// - capturing units pick first or third timer; unit one on third puts unit two there too.
// - a compare trigger resets its timer, maybe upsetting the other.
// - triggers reset their time base; only unit two starts conversion.
// - pwm units share second timer frequency and update rate.
// - unit two pin: port c bit 1 if select is 1, else port b bit 3.
// - a capture copies the full 16-bit timer into the pair.
// - mode picks falling, rising, every 4th or every 16th rising edge.
// - mode 0110 is every fourth rising edge, 0111 every sixteenth.
// - every capture sets the unit flag; only software clears it.
// - a later capture overwrites an unread pair.
// - with the pin as output, a latch write can capture.
// - mode change may raise a false flag; software masks and clears it.
// - prescaler clears when off, not capturing, or reset.
// - direct prescaler switch keeps the count and may set the flag.
`timescale 1ns/10ps

module ccts_top #(
  parameter int TIMER_W = 16
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  // register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output logic      [7:0]         reg_rdata,
  // timer counts, same clock domain
  input  wire logic [TIMER_W-1:0] first_timer_count,
  input  wire logic [TIMER_W-1:0] third_timer_count,
  // timer and converter triggers
  output logic                    first_timer_reset,
  output logic                    third_timer_reset,
  output logic                    adc_start,
  // time base chosen per unit
  output logic      [1:0]         unit1_time_base,
  output logic      [1:0]         unit2_time_base,
  // event flags
  output logic      [1:0]         unit_event_flag,
  // unit one pin
  input  wire logic               unit1_pin_in,
  output logic                    unit1_pin_out,
  output logic                    unit1_pin_oe,
  // unit two pin, first routing choice
  input  wire logic               port_c_bit_1_in,
  output logic                    port_c_bit_1_out,
  output logic                    port_c_bit_1_oe,
  // unit two pin, second routing choice
  input  wire logic               port_b_bit_3_in,
  output logic                    port_b_bit_3_out,
  output logic                    port_b_bit_3_oe
);

  // -----------------------------------------------------------------
  // helper functions
  // -----------------------------------------------------------------

  // terminal count of the edge prescaler for a capture mode
  function automatic logic [3:0] presc_top(input logic [3:0] mode);
    logic [3:0] top;
    top = ccts_pkg::PRESC_TOP_1;
    if (mode == ccts_pkg::MODE_CAP_RISE4) begin
      top = ccts_pkg::PRESC_TOP_4;
    end else if (mode == ccts_pkg::MODE_CAP_RISE16) begin
      top = ccts_pkg::PRESC_TOP_16;
    end
    return top;
  endfunction

  // class of operation held in the upper mode bits
  function automatic logic [1:0] mode_class(input logic [3:0] mode);
    return mode[3:2];
  endfunction

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic [7:0]         ctrl      [2];
  logic [15:0]        pair      [2];
  logic [7:0]         t3_ctrl;
  logic [1:0]         flag;
  logic [1:0]         int_en;
  logic [4:0]         pin_cfg;
  logic [2:0]         pin_meta;
  logic [2:0]         pin_sync;
  logic [1:0]         pin_prev;
  logic [3:0]         presc     [2];
  logic [1:0]         match_prev;

  // per-unit decode
  logic [3:0]         mode      [2];
  logic [1:0]         is_cap;
  logic [1:0]         is_cmp;
  logic [1:0]         is_pwm;
  logic [1:0]         use_third;
  logic [15:0]        tb_count  [2];
  logic [1:0]         pin_level;
  logic [1:0]         edge_hit;
  logic [1:0]         cap_fire;
  logic [1:0]         match;
  logic [1:0]         cmp_fire;
  logic [1:0]         trig;
  logic [3:0]         next_presc [2];
  logic [15:0]        next_pair  [2];
  logic [7:0]         next_ctrl  [2];
  logic [1:0]         ctrl_wr;
  logic [1:0]         low_wr;
  logic [1:0]         high_wr;
  logic [1:0]         next_tb    [2];

  // -----------------------------------------------------------------
  // register port decode
  // -----------------------------------------------------------------

  // one-hot write selects from the address
  assign ctrl_wr[0] = reg_write && (reg_addr == ccts_pkg::REG_CTRL_1);
  assign ctrl_wr[1] = reg_write && (reg_addr == ccts_pkg::REG_CTRL_2);
  assign low_wr[0]  = reg_write && (reg_addr == ccts_pkg::REG_LOW_1);
  assign low_wr[1]  = reg_write && (reg_addr == ccts_pkg::REG_LOW_2);
  assign high_wr[0] = reg_write && (reg_addr == ccts_pkg::REG_HIGH_1);
  assign high_wr[1] = reg_write && (reg_addr == ccts_pkg::REG_HIGH_2);

  wire       t3_wr    = reg_write && (reg_addr == ccts_pkg::REG_T3_CTRL);
  wire       flags_wr = reg_write && (reg_addr == ccts_pkg::REG_FLAGS);
  wire       pin_wr   = reg_write && (reg_addr == ccts_pkg::REG_PIN_CFG);

  // read selection; unmapped addresses read as zero
  wire [7:0] flags_view = {2'h0, int_en, 2'h0, flag};
  wire [7:0] rd_mux =
      (reg_addr == ccts_pkg::REG_CTRL_1)  ? ctrl[0] :
      (reg_addr == ccts_pkg::REG_LOW_1)   ? pair[0][7:0] :
      (reg_addr == ccts_pkg::REG_HIGH_1)  ? pair[0][15:8] :
      (reg_addr == ccts_pkg::REG_CTRL_2)  ? ctrl[1] :
      (reg_addr == ccts_pkg::REG_LOW_2)   ? pair[1][7:0] :
      (reg_addr == ccts_pkg::REG_HIGH_2)  ? pair[1][15:8] :
      (reg_addr == ccts_pkg::REG_T3_CTRL) ? t3_ctrl :
      (reg_addr == ccts_pkg::REG_FLAGS)   ? flags_view :
      (reg_addr == ccts_pkg::REG_PIN_CFG) ? {3'h0, pin_cfg} : 8'h00;

  // -----------------------------------------------------------------
  // pin routing
  // -----------------------------------------------------------------

  // unit two follows the select bit, muxed after the synchronisers
  wire pin_select = pin_cfg[ccts_pkg::PIN_SEL_BIT];
  wire unit2_raw  = pin_select ? pin_sync[1] : pin_sync[2];
  wire dir_in_1   = pin_cfg[ccts_pkg::DIR_LSB];
  wire dir_in_2   = pin_cfg[ccts_pkg::DIR_LSB + 1];
  wire latch_1    = pin_cfg[ccts_pkg::LATCH_LSB];
  wire latch_2    = pin_cfg[ccts_pkg::LATCH_LSB + 1];

  // an output pin sees its own latch, so a latch write can capture
  assign pin_level[0] = dir_in_1 ? pin_sync[0] : latch_1;
  assign pin_level[1] = dir_in_2 ? unit2_raw : latch_2;

  // high select bit: both units on third timer,
  // low bit: unit two only
  assign use_third[0] = t3_ctrl[ccts_pkg::T3_SEL_HIGH_BIT];
  assign use_third[1] = t3_ctrl[ccts_pkg::T3_SEL_HIGH_BIT]
                        | t3_ctrl[ccts_pkg::T3_SEL_LOW_BIT];

  // -----------------------------------------------------------------
  // per-unit capture, compare and time base decode
  // -----------------------------------------------------------------
  for (genvar u = 0; u < 2; u++) begin : g_unit
    // mode class decode
    assign mode[u]   = ctrl[u][3:0];
    assign is_cap[u] = mode_class(mode[u]) == ccts_pkg::CLASS_CAPTURE;
    assign is_cmp[u] = (mode_class(mode[u]) == ccts_pkg::CLASS_COMPARE)
                       || (mode[u] == ccts_pkg::MODE_CMP_TOGGLE);
    assign is_pwm[u] = mode_class(mode[u]) == ccts_pkg::CLASS_PWM;

    // both capture/compare units may point at the same timer
    assign tb_count[u] = use_third[u] ? third_timer_count
                                      : first_timer_count;

    // falling edge for the falling mode, rising otherwise
    assign edge_hit[u] = (mode[u] == ccts_pkg::MODE_CAP_FALL)
                         ? (pin_prev[u] && !pin_level[u])
                         : (!pin_prev[u] && pin_level[u]);

    // a capture fires when the prescaler reaches its terminal count
    assign cap_fire[u] = is_cap[u] && edge_hit[u]
                         && (presc[u] == presc_top(mode[u]));

    // prescaler clears outside capture, keeps its count across settings
    assign next_presc[u] =
        !is_cap[u] ? 4'h0 :
        !edge_hit[u] ? presc[u] :
        (presc[u] == presc_top(mode[u])) ? 4'h0 : presc[u] + 4'h1;

    // compare match fires once per entry into the matching value
    assign match[u]    = is_cmp[u] && (tb_count[u] == pair[u]);
    assign cmp_fire[u] = match[u] && !match_prev[u];
    assign trig[u]     = cmp_fire[u] && (mode[u] == ccts_pkg::MODE_CMP_TRIG);

    // captured count wins over a software byte write in the same cycle
    assign next_pair[u] =
        cap_fire[u] ? tb_count[u] :
        low_wr[u]   ? {pair[u][15:8], reg_wdata} :
        high_wr[u]  ? {reg_wdata, pair[u][7:0]} : pair[u];

    // control writes keep only implemented bits
    assign next_ctrl[u] = ctrl_wr[u]
        ? (reg_wdata & ((u == 0) ? ccts_pkg::CTRL_MASK_1 : ccts_pkg::CTRL_MASK_2))
        : ctrl[u];

    // pwm uses the second timer, so two pwm units agree
    assign next_tb[u] = is_pwm[u]    ? 2'(ccts_pkg::CCTS_TB_SECOND) :
                        use_third[u] ? 2'(ccts_pkg::CCTS_TB_THIRD)
                                     : 2'(ccts_pkg::CCTS_TB_FIRST);
  end

  // flags: a hardware set beats a same-cycle clear
  wire [1:0] flag_set  = cap_fire | cmp_fire;
  wire [1:0] next_flag = (flags_wr ? reg_wdata[ccts_pkg::FLAG_LSB +: 2] : flag)
                         | flag_set;

  // trigger resets the triggering unit's timer
  wire next_first_rst = |(trig & ~use_third);
  wire next_third_rst = |(trig & use_third);
  wire next_adc_start = trig[1];

  // -----------------------------------------------------------------
  // synchronisers and edge history
  // -----------------------------------------------------------------

  // two stages on every pin before anything looks at it
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {port_b_bit_3_in, port_c_bit_1_in, unit1_pin_in};
      pin_sync <= pin_meta;
    end
  end

  // previous levels for edge and match detection
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_prev   <= 2'h0;
      match_prev <= 2'h0;
    end else begin
      pin_prev   <= pin_level;
      match_prev <= match;
    end
  end

  // -----------------------------------------------------------------
  // unit registers
  // -----------------------------------------------------------------

  // control, value pair and prescaler per unit
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 2; i++) begin
        ctrl[i]  <= ccts_pkg::CTRL_RESET;
        pair[i]  <= 16'h0000;
        presc[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        ctrl[i]  <= next_ctrl[i];
        pair[i]  <= next_pair[i];
        presc[i] <= next_presc[i];
      end
    end
  end

  // shared configuration: timer select, flags, enables, pin setup
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      t3_ctrl <= ccts_pkg::T3_CTRL_RESET;
      flag    <= 2'h0;
      int_en  <= 2'h0;
      pin_cfg <= ccts_pkg::PIN_CFG_RESET[4:0];
    end else begin
      t3_ctrl <= t3_wr ? reg_wdata : t3_ctrl;
      flag    <= next_flag;
      int_en  <= flags_wr ? reg_wdata[ccts_pkg::IE_LSB +: 2] : int_en;
      pin_cfg <= pin_wr ? reg_wdata[4:0] : pin_cfg;
    end
  end

  // -----------------------------------------------------------------
  // registered outputs
  // -----------------------------------------------------------------

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_read ? rd_mux : 8'h00;
    end
  end

  // trigger pulses, time base report and flags
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      first_timer_reset <= 1'b0;
      third_timer_reset <= 1'b0;
      adc_start         <= 1'b0;
      unit1_time_base   <= 2'(ccts_pkg::CCTS_TB_FIRST);
      unit2_time_base   <= 2'(ccts_pkg::CCTS_TB_FIRST);
      unit_event_flag   <= 2'h0;
    end else begin
      first_timer_reset <= next_first_rst;
      third_timer_reset <= next_third_rst;
      adc_start         <= next_adc_start;
      unit1_time_base   <= next_tb[0];
      unit2_time_base   <= next_tb[1];
      unit_event_flag   <= next_flag;
    end
  end

  // pin drivers; unit two drives only its routed pin
  // direction stays with software
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      unit1_pin_out    <= 1'b0;
      unit1_pin_oe     <= 1'b0;
      port_c_bit_1_out <= 1'b0;
      port_c_bit_1_oe  <= 1'b0;
      port_b_bit_3_out <= 1'b0;
      port_b_bit_3_oe  <= 1'b0;
    end else begin
      unit1_pin_out    <= latch_1;
      unit1_pin_oe     <= !dir_in_1;
      port_c_bit_1_out <= pin_select && latch_2;
      port_c_bit_1_oe  <= pin_select && !dir_in_2;
      port_b_bit_3_out <= !pin_select && latch_2;
      port_b_bit_3_oe  <= !pin_select && !dir_in_2;
    end
  end

endmodule

//--- ccts_pkg.sv
// constants shared by the capture and timer-select unit
package ccts_pkg;

  // -----------------------------------------------------------------
  // register bus geometry
  // -----------------------------------------------------------------
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam int          NUM_UNITS       = 2;

  // -----------------------------------------------------------------
  // register indices on the plain register port
  // -----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL_1      = 4'h0;
  localparam logic [3:0]  REG_LOW_1       = 4'h1;
  localparam logic [3:0]  REG_HIGH_1      = 4'h2;
  localparam logic [3:0]  REG_CTRL_2      = 4'h3;
  localparam logic [3:0]  REG_LOW_2       = 4'h4;
  localparam logic [3:0]  REG_HIGH_2      = 4'h5;
  localparam logic [3:0]  REG_T3_CTRL     = 4'h6;
  localparam logic [3:0]  REG_FLAGS       = 4'h7;
  localparam logic [3:0]  REG_PIN_CFG     = 4'h8;

  // -----------------------------------------------------------------
  // field layouts and reset values
  // -----------------------------------------------------------------
  localparam logic [7:0]  CTRL_MASK_1     = 8'hff;
  localparam logic [7:0]  CTRL_MASK_2     = 8'h3f;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  T3_CTRL_RESET   = 8'h00;
  localparam int          T3_SEL_LOW_BIT  = 3;
  localparam int          T3_SEL_HIGH_BIT = 6;
  localparam int          FLAG_LSB        = 0;
  localparam int          IE_LSB          = 4;
  localparam logic [7:0]  FLAGS_MASK      = 8'h33;
  localparam int          PIN_SEL_BIT     = 0;
  localparam int          DIR_LSB         = 1;
  localparam int          LATCH_LSB       = 3;
  localparam logic [7:0]  PIN_CFG_MASK    = 8'h1f;
  localparam logic [7:0]  PIN_CFG_RESET   = 8'h07;

  // -----------------------------------------------------------------
  // mode field encodings
  // -----------------------------------------------------------------
  localparam logic [3:0]  MODE_OFF        = 4'h0;
  localparam logic [3:0]  MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0]  MODE_CAP_FALL   = 4'h4;
  localparam logic [3:0]  MODE_CAP_RISE   = 4'h5;
  localparam logic [3:0]  MODE_CAP_RISE4  = 4'h6;
  localparam logic [3:0]  MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0]  MODE_CMP_TRIG   = 4'hb;
  localparam logic [1:0]  CLASS_CAPTURE   = 2'h1;
  localparam logic [1:0]  CLASS_COMPARE   = 2'h2;
  localparam logic [1:0]  CLASS_PWM       = 2'h3;

  // -----------------------------------------------------------------
  // prescaler terminal counts
  // -----------------------------------------------------------------
  localparam logic [3:0]  PRESC_TOP_1     = 4'h0;
  localparam logic [3:0]  PRESC_TOP_4     = 4'h3;
  localparam logic [3:0]  PRESC_TOP_16    = 4'hf;

  // time base that a unit is steered to
  typedef enum logic [1:0] {
    CCTS_TB_FIRST,
    CCTS_TB_THIRD,
    CCTS_TB_SECOND
  } ccts_tb_t;

endpackage

//--- ccts_top_monitor.sv
// port-level assertions for the capture and timer-select unit
`timescale 1ns/10ps
module ccts_monitor (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  // outputs and pins
  input wire logic       adc_start,
  input wire logic [1:0] unit1_time_base,
  input wire logic [1:0] unit2_time_base,
  input wire logic [1:0] unit_event_flag,
  input wire logic       unit1_pin_in,
  input wire logic       unit1_pin_oe,
  input wire logic       port_c_bit_1_oe,
  input wire logic       port_b_bit_3_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] mode1;
  logic [3:0] mode2;
  logic [7:0] t3;
  logic [7:0] pin;
  logic [1:0] quiet;
  // -----------------------------------------------------------------
  // shadow of software writes; time base, routing and capture checks judge only settled states
  // -----------------------------------------------------------------
  wire       flag_wr = reg_write && (reg_addr == ccts_pkg::REG_FLAGS);
  wire [1:0] exp_tb1 = (mode1[3:2] == 2'h3) ? 2'h2 : {1'b0, t3[6]};
  wire [1:0] exp_tb2 = (mode2[3:2] == 2'h3) ? 2'h2 : {1'b0, t3[6] | t3[3]};
  // quiet counts cycles since the last write
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mode1 <= 4'h0;
      mode2 <= 4'h0;
      t3    <= 8'h00;
      pin   <= 8'h07;
      quiet <= 2'h0;
    end else begin
      quiet <= reg_write ? 2'h0 : ((quiet == 2'h3) ? quiet : quiet + 2'h1);
      if (reg_write && reg_addr == ccts_pkg::REG_CTRL_1) mode1 <= reg_wdata[3:0];
      if (reg_write && reg_addr == ccts_pkg::REG_CTRL_2) mode2 <= reg_wdata[3:0];
      if (reg_write && reg_addr == ccts_pkg::REG_T3_CTRL) t3 <= reg_wdata;
      if (reg_write && reg_addr == ccts_pkg::REG_PIN_CFG) pin <= reg_wdata;
    end
  end
  sequence s_rise1;
    quiet == 2'h3 && mode1 == ccts_pkg::MODE_CAP_RISE && pin[1] && $rose(unit1_pin_in);
  endsequence
  property p_rdata_idle;
    !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_ctrl2_upper;
    $past(reg_read && reg_addr == ccts_pkg::REG_CTRL_2) |-> reg_rdata[7:6] == 2'h0;
  endproperty
  a_ctrl2_upper: assert property (p_ctrl2_upper) else $error("unit two ctrl top bits");
  property p_time_base;
    quiet == 2'h3 && mode1[3:2] != 2'h0 && mode2[3:2] != 2'h0
      |-> unit1_time_base == exp_tb1 && unit2_time_base == exp_tb2;
  endproperty
  a_time_base: assert property (p_time_base) else $error("time base wrong");
  property p_flag_sticky;
    $fell(unit_event_flag[0]) || $fell(unit_event_flag[1]) |-> $past(flag_wr) || $past(flag_wr, 2);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by itself");
  property p_adc_unit2;
    adc_start |-> mode2 == ccts_pkg::MODE_CMP_TRIG;
  endproperty
  a_adc_unit2: assert property (p_adc_unit2) else $error("conversion start not unit two");
  property p_routing;
    quiet == 2'h3 |-> (pin[0] || !port_c_bit_1_oe) && (!pin[0] || !port_b_bit_3_oe)
      && unit1_pin_oe == !pin[1];
  endproperty
  a_routing: assert property (p_routing) else $error("pin routing or drive wrong");
  property p_capture;
    s_rise1 |-> ##[2:4] unit_event_flag[0];
  endproperty
  a_capture: assert property (p_capture) else $error("rising edge not captured");
  property p_off_quiet;
    $rose(unit_event_flag[0]) |-> mode1 != ccts_pkg::MODE_OFF || $past(flag_wr) || $past(flag_wr, 2);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("flag while unit off");
endmodule

//--- ccts_edge_src.sv
// edge source model standing on the unit pins
`timescale 1ns/10ps
module ccts_edge_src (
  // clock
  input  wire logic       ref_clk,
  // levels: bit0 unit one, bit1 port c bit 1, bit2 port b bit 3
  output logic      [2:0] pins
);
  // pins are inputs driven from outside; idle low
  initial pins = 3'h0;
  // levels change just after a clock edge, like a synchronised source
  task automatic drive(input int sel, input logic v, input int hold);
    @(posedge ref_clk);
    pins[sel] <= v;
    repeat (hold) @(posedge ref_clk);
  endtask
endmodule

//--- ccts_top_tb.sv
// self-checking bench for the capture and timer-select unit
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module ccts_top_tb;
  logic        ref_clk, reset_n, reg_write, reg_read;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic [15:0] first_timer_count, third_timer_count, v;
  logic        first_timer_reset, third_timer_reset, adc_start;
  logic [1:0]  unit1_time_base, unit2_time_base, unit_event_flag;
  logic        unit1_pin_out, unit1_pin_oe, port_c_bit_1_out, port_c_bit_1_oe;
  logic        port_b_bit_3_out, port_b_bit_3_oe;
  logic [2:0]  pins;
  int          miscompares, tests_run, adc_seen, trst_seen, frst_seen;
  logic [7:0]  rst_val [10] = '{8: 8'h07, default: 8'h00};
  logic [3:0]  modes [3] = '{ccts_pkg::MODE_CAP_RISE, ccts_pkg::MODE_CMP_TRIG, 4'hc};
  logic [7:0]  t3s [3] = '{8'h00, 8'h08, 8'h40};
  // wire level: a driving unit wins over the edge source
  wire unit1_pin_in    = unit1_pin_oe ? unit1_pin_out : pins[0];
  wire port_c_bit_1_in = port_c_bit_1_oe ? port_c_bit_1_out : pins[1];
  wire port_b_bit_3_in = port_b_bit_3_oe ? port_b_bit_3_out : pins[2];
  ccts_top u_dut (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .first_timer_count, .third_timer_count, .first_timer_reset, .third_timer_reset,
    .adc_start, .unit1_time_base, .unit2_time_base, .unit_event_flag, .unit1_pin_in,
    .unit1_pin_out, .unit1_pin_oe, .port_c_bit_1_in, .port_c_bit_1_out, .port_c_bit_1_oe,
    .port_b_bit_3_in, .port_b_bit_3_out, .port_b_bit_3_oe);
  ccts_edge_src u_src (.ref_clk, .pins);
  // -----------------------------------------------------------------
  // clock, pulse counters and bus tasks
  // -----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // pulses last one cycle, so a count per edge catches repeats
  always @(posedge ref_clk) begin
    if (adc_start === 1'b1) adc_seen++;
    if (third_timer_reset === 1'b1) trst_seen++;
    if (first_timer_reset === 1'b1) frst_seen++;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic clr();
    wr(ccts_pkg::REG_FLAGS, 8'h00);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] r);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 r = reg_rdata;
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    rd(a, d);
    `CHK(d, e)
  endtask
  task automatic rd_pair(input logic [3:0] lo);
    rd(lo, v[7:0]);
    rd(4'(lo + 4'h1), v[15:8]);
  endtask
  task automatic edges(input int sel, input int n);
    repeat (n) begin
      u_src.drive(sel, 1'b1, 3);
      u_src.drive(sel, 1'b0, 3);
    end
  endtask
  function automatic logic [1:0] exp_tb(input logic [3:0] m, input logic [7:0] t, input logic u2);
    if (m[3:2] == 2'h3) return 2'h2;
    return {1'b0, t[6] | (u2 & t[3])};
  endfunction
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    finish_test();
  end
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    {reset_n, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {first_timer_count, third_timer_count} = '0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 10; i++) chk_rd(4'(i), rst_val[i]);
    wr(ccts_pkg::REG_CTRL_2, 8'hff);
    chk_rd(ccts_pkg::REG_CTRL_2, 8'h3f);
    wr(ccts_pkg::REG_LOW_1, 8'ha5);
    chk_rd(ccts_pkg::REG_LOW_1, 8'ha5);
    // every class pairing under each timer selection
    for (int a = 0; a < 3; a++) for (int b = 0; b < 3; b++) for (int t = 0; t < 3; t++) begin
      wr(ccts_pkg::REG_CTRL_1, {4'h0, modes[a]});
      wr(ccts_pkg::REG_CTRL_2, {4'h0, modes[b]});
      wr(ccts_pkg::REG_T3_CTRL, t3s[t]);
      repeat (4) @(posedge ref_clk);
      `CHK(unit1_time_base, exp_tb(modes[a], t3s[t], 1'b0))
      `CHK(unit2_time_base, exp_tb(modes[b], t3s[t], 1'b1))
    end
    wr(ccts_pkg::REG_CTRL_2, 8'h00);
    wr(ccts_pkg::REG_T3_CTRL, 8'h08);
    wr(ccts_pkg::REG_CTRL_1, {4'h0, ccts_pkg::MODE_CAP_RISE});
    clr();
    first_timer_count <= 16'h1234;
    edges(0, 1);
    rd_pair(ccts_pkg::REG_LOW_1);
    `CHK(v, 16'h1234)
    `CHK(unit_event_flag[0], 1'b1)
    first_timer_count <= 16'h5678;
    edges(0, 1);
    rd_pair(ccts_pkg::REG_LOW_1);
    `CHK(v, 16'h5678)
    clr();
    repeat (3) @(posedge ref_clk);
    `CHK(unit_event_flag[0], 1'b0)
    // falling mode ignores the rising half
    wr(ccts_pkg::REG_CTRL_1, {4'h0, ccts_pkg::MODE_CAP_FALL});
    clr();
    first_timer_count <= 16'h0abc;
    u_src.drive(0, 1'b1, 5);
    `CHK(unit_event_flag[0], 1'b0)
    u_src.drive(0, 1'b0, 5);
    `CHK(unit_event_flag[0], 1'b1)
    // prescaled capture on unit two, third timer
    for (int k = 0; k < 2; k++) begin
      wr(ccts_pkg::REG_CTRL_2, 8'h00);
      wr(ccts_pkg::REG_CTRL_2, {4'h0, 4'(ccts_pkg::MODE_CAP_RISE4 + k)});
      edges(1, 2);
      wr(ccts_pkg::REG_CTRL_2, 8'h00);
      wr(ccts_pkg::REG_CTRL_2, {4'h0, 4'(ccts_pkg::MODE_CAP_RISE4 + k)});
      clr();
      third_timer_count <= k ? 16'h0016 : 16'h0004;
      edges(1, k ? 15 : 3);
      `CHK(unit_event_flag[1], 1'b0)
      edges(1, 1);
      `CHK(unit_event_flag[1], 1'b1)
      rd_pair(ccts_pkg::REG_LOW_2);
      `CHK(v, k ? 16'h0016 : 16'h0004)
    end
    // unit two routing follows the pin select
    wr(ccts_pkg::REG_CTRL_2, {4'h0, ccts_pkg::MODE_CAP_RISE});
    for (int s = 0; s < 2; s++) begin
      wr(ccts_pkg::REG_PIN_CFG, s ? 8'h06 : 8'h07);
      clr();
      edges(s ? 1 : 2, 1);
      `CHK(unit_event_flag[1], 1'b0)
      edges(s ? 2 : 1, 1);
      `CHK(unit_event_flag[1], 1'b1)
    end
    // unit one as output: a latch write makes the edge
    wr(ccts_pkg::REG_CTRL_1, {4'h0, ccts_pkg::MODE_CAP_RISE});
    wr(ccts_pkg::REG_PIN_CFG, 8'h05);
    clr();
    wr(ccts_pkg::REG_PIN_CFG, 8'h0d);
    repeat (5) @(posedge ref_clk);
    `CHK(unit_event_flag[0], 1'b1)
    `CHK(unit1_pin_oe, 1'b1)
    // trigger compare: unit two on third timer, then unit one on first
    wr(ccts_pkg::REG_PIN_CFG, 8'h07);
    wr(ccts_pkg::REG_CTRL_2, 8'h00);
    wr(ccts_pkg::REG_LOW_2, 8'h42);
    wr(ccts_pkg::REG_HIGH_2, 8'h00);
    {first_timer_count, third_timer_count} <= '0;
    wr(ccts_pkg::REG_CTRL_2, {4'h0, ccts_pkg::MODE_CMP_TRIG});
    clr();
    {adc_seen, trst_seen, frst_seen} = '0;
    third_timer_count <= 16'h0042;
    repeat (3) @(posedge ref_clk);
    third_timer_count <= 16'h0043;
    repeat (3) @(posedge ref_clk);
    `CHK(adc_seen, 1)
    `CHK(trst_seen, 1)
    `CHK(unit_event_flag[1], 1'b1)
    wr(ccts_pkg::REG_CTRL_1, {4'h0, ccts_pkg::MODE_CMP_TRIG});
    first_timer_count <= 16'h0abc; // unit one pair holds the latch capture
    repeat (4) @(posedge ref_clk);
    `CHK(frst_seen, 1)
    `CHK(adc_seen, 1)
    finish_test();
  end
endmodule
bind ccts_top ccts_monitor u_mon (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .adc_start, .unit1_time_base, .unit2_time_base, .unit_event_flag,
  .unit1_pin_in, .unit1_pin_oe, .port_c_bit_1_oe, .port_b_bit_3_oe);
